// >>> common/tmf_pkg.sv
// Purpose: shared constants and types for the timer and logic function bank
// Assumes: 50 MHz core clock, APB register access with 32-bit data
// Notes:   offsets are byte addresses; every register is one aligned word
package tmf_pkg;

    // bank shape
    localparam int NUM_SLOTS = 16;
    localparam int SLOT_W    = 4;
    localparam int DELAY_W   = 16;
    localparam int ADDR_W    = 8;

    // seconds tick timing
    localparam int CLK_FREQ_HZ   = 50_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES   = CLK_FREQ_HZ * TICK_PERIOD_S;

    // register map
    localparam logic [7:0] CFG_BASE   = 8'h00; // 16 words, one per slot
    localparam logic [7:0] ROUTE_BASE = 8'h40; // 16 words, one per slot
    localparam logic [7:0] STAT_RUN   = 8'h80; // running timers
    localparam logic [7:0] STAT_OUT   = 8'h84; // last value sent per slot
    localparam logic [7:0] STAT_VALID = 8'h88; // gate input validity

    // slot configuration word fields
    localparam int CFG_FUNC_LSB  = 0;  // 2 bits
    localparam int CFG_TTYPE_LSB = 2;  // 2 bits
    localparam int CFG_GATE_LSB  = 4;  // 3 bits
    localparam int CFG_INV_BIT   = 7;
    localparam int CFG_DELAY_LSB = 16; // DELAY_W bits, seconds

    // chaining word fields
    localparam int ROUTE_EN_BIT   = 0;
    localparam int ROUTE_PORT_BIT = 1;
    localparam int ROUTE_TGT_LSB  = 4; // SLOT_W bits

    // reset values
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
    localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;

    // function kinds
    typedef enum logic [1:0] {
        TMF_FN_OFF   = 2'h0,
        TMF_FN_TIMER = 2'h1,
        TMF_FN_LOGIC = 2'h2
    } tmf_func_t;

    // timer kinds
    typedef enum logic [1:0] {
        TMF_T_ON_DLY  = 2'h0,
        TMF_T_OFF_DLY = 2'h1,
        TMF_T_BOTH    = 2'h2,
        TMF_T_IMPULSE = 2'h3
    } tmf_ttype_t;

    // gate kinds
    typedef enum logic [2:0] {
        TMF_G_AND  = 3'h0,
        TMF_G_OR   = 3'h1,
        TMF_G_XOR  = 3'h2,
        TMF_G_NAND = 3'h3,
        TMF_G_NOR  = 3'h4,
        TMF_G_XNOR = 3'h5,
        TMF_G_INV  = 3'h6
    } tmf_gate_t;

    // timer state
    typedef enum logic {
        TMF_ST_IDLE,
        TMF_ST_RUN
    } tmf_tstate_t;

endpackage

// >>> logic/tmf_slot.sv
// Purpose: one function slot: disabled, delay timer or logic gate
// Assumes: one event per cycle at most, tick_i one cycle per second
// Notes:   a pending send waits in this slot until the bank emits it, a newer send replaces it or disabling drops it
`timescale 1ns/1ps
module tmf_slot #(
    parameter int DELAY_W = tmf_pkg::DELAY_W
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // configuration and time base
    input  wire logic [31:0] cfg_i,
    input  wire logic        tick_i,
    // incoming telegram
    input  wire logic        ev_valid_i,
    input  wire logic        ev_port_i,
    input  wire logic        ev_value_i,
    // outgoing telegram
    input  wire logic        sent_i,
    output logic             send_pend_o,
    output logic             send_value_o,
    // status
    output logic             running_o,
    output logic [1:0]       valid_o
);

    // gate truth function
    function automatic logic gate_eval(input logic [2:0] g,
                                       input logic a, input logic b);
        case (g)
            tmf_pkg::TMF_G_AND:  gate_eval = a & b;
            tmf_pkg::TMF_G_OR:   gate_eval = a | b;
            tmf_pkg::TMF_G_XOR:  gate_eval = a ^ b;
            tmf_pkg::TMF_G_NAND: gate_eval = ~(a & b);
            tmf_pkg::TMF_G_NOR:  gate_eval = ~(a | b);
            tmf_pkg::TMF_G_XNOR: gate_eval = ~(a ^ b);
            default:             gate_eval = 1'b0;
        endcase
    endfunction

    logic [1:0]         func;
    logic [1:0]         ttype;
    logic [2:0]         gate;
    logic               inv;
    logic [DELAY_W-1:0] delay;

    assign func  = cfg_i[tmf_pkg::CFG_FUNC_LSB +: 2];
    assign ttype = cfg_i[tmf_pkg::CFG_TTYPE_LSB +: 2];
    assign gate  = cfg_i[tmf_pkg::CFG_GATE_LSB +: 3];
    assign inv   = cfg_i[tmf_pkg::CFG_INV_BIT];
    assign delay = cfg_i[tmf_pkg::CFG_DELAY_LSB +: DELAY_W];

    tmf_pkg::tmf_tstate_t state, next_state;
    logic [DELAY_W-1:0]   cnt, next_cnt;
    logic                 tgt, next_tgt;
    logic                 in_a, next_in_a, in_b, next_in_b;
    logic                 ok_a, next_ok_a, ok_b, next_ok_b;
    logic                 pend, next_pend, pval, next_pval;

    // next state of timer, gate inputs and send slot
    always_comb begin
        logic do_send;
        logic sv;
        do_send    = 1'b0;
        sv         = 1'b0;
        next_state = state;
        next_cnt   = cnt;
        next_tgt   = tgt;
        next_in_a  = in_a;
        next_in_b  = in_b;
        next_ok_a  = ok_a;
        next_ok_b  = ok_b;
        next_pend  = sent_i ? 1'b0 : pend;
        next_pval  = pval;
        case (func)
            tmf_pkg::TMF_FN_TIMER: begin
                if (state == tmf_pkg::TMF_ST_RUN) begin
                    if (cnt == delay) begin
                        do_send    = 1'b1;
                        sv         = tgt;
                        next_state = tmf_pkg::TMF_ST_IDLE;
                    end else if (tick_i) begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                if (ev_valid_i) begin
                    case (ttype)
                        tmf_pkg::TMF_T_ON_DLY: begin
                            if (ev_value_i) begin
                                if (next_state != tmf_pkg::TMF_ST_RUN) begin
                                    next_state = tmf_pkg::TMF_ST_RUN;
                                    next_cnt   = '0;
                                    next_tgt   = 1'b1;
                                end
                            end else begin
                                next_state = tmf_pkg::TMF_ST_IDLE;
                                do_send    = 1'b1;
                                sv         = 1'b0;
                            end
                        end
                        tmf_pkg::TMF_T_OFF_DLY: begin
                            if (!ev_value_i) begin
                                if (next_state != tmf_pkg::TMF_ST_RUN) begin
                                    next_state = tmf_pkg::TMF_ST_RUN;
                                    next_cnt   = '0;
                                    next_tgt   = 1'b0;
                                end
                            end else begin
                                next_state = tmf_pkg::TMF_ST_IDLE;
                                do_send    = 1'b1;
                                sv         = 1'b1;
                            end
                        end
                        tmf_pkg::TMF_T_BOTH: begin
                            // opposite value while running cancels
                            if (next_state == tmf_pkg::TMF_ST_RUN &&
                                next_tgt != ev_value_i) begin
                                next_state = tmf_pkg::TMF_ST_IDLE;
                            end else if (next_state != tmf_pkg::TMF_ST_RUN)
                            begin
                                next_state = tmf_pkg::TMF_ST_RUN;
                                next_cnt   = '0;
                                next_tgt   = ev_value_i;
                            end
                        end
                        default: begin
                            if (ev_value_i) begin
                                do_send    = 1'b1;
                                sv         = 1'b1;
                                next_state = tmf_pkg::TMF_ST_RUN;
                                next_cnt   = '0;
                                next_tgt   = 1'b0;
                            end else begin
                                next_state = tmf_pkg::TMF_ST_IDLE;
                            end
                        end
                    endcase
                end
                sv = sv ^ inv;
            end
            tmf_pkg::TMF_FN_LOGIC: begin
                next_state = tmf_pkg::TMF_ST_IDLE;
                if (ev_valid_i) begin
                    if (gate == tmf_pkg::TMF_G_INV) begin
                        do_send = 1'b1;
                        sv      = ~ev_value_i;
                    end else begin
                        if (ev_port_i) begin
                            next_in_b = ev_value_i;
                            next_ok_b = 1'b1;
                        end else begin
                            next_in_a = ev_value_i;
                            next_ok_a = 1'b1;
                        end
                        do_send = next_ok_a & next_ok_b;
                        sv = gate_eval(gate, next_in_a, next_in_b);
                    end
                end
            end
            default: begin
                // disabled slot drops its timer run, input validity and pending send, and stays silent
                next_state = tmf_pkg::TMF_ST_IDLE;
                next_ok_a  = 1'b0;
                next_ok_b  = 1'b0;
                next_pend  = 1'b0;
            end
        endcase
        // a new send wins over the clear of the old one
        if (do_send) begin
            next_pend = 1'b1;
            next_pval = sv;
        end
    end

    // registers; reset cancels timers and validity silently
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= tmf_pkg::TMF_ST_IDLE;
            cnt   <= '0;
            tgt   <= 1'b0;
            in_a  <= 1'b0;
            in_b  <= 1'b0;
            ok_a  <= 1'b0;
            ok_b  <= 1'b0;
            pend  <= 1'b0;
            pval  <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            tgt   <= next_tgt;
            in_a  <= next_in_a;
            in_b  <= next_in_b;
            ok_a  <= next_ok_a;
            ok_b  <= next_ok_b;
            pend  <= next_pend;
            pval  <= next_pval;
        end
    end

    assign send_pend_o  = pend;
    assign send_value_o = pval;
    assign running_o    = (state == tmf_pkg::TMF_ST_RUN);
    assign valid_o      = {ok_b, ok_a};

endmodule

// >>> logic/tmf_bank.sv
// Purpose: bank of sixteen timer and logic functions with APB registers
// Assumes: telegrams arrive as one-cycle strobes synchronous to core_clk_i
// Notes:   one telegram leaves per cycle; chained outputs feed back inside
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module tmf_bank #(
    parameter int NUM_SLOTS   = tmf_pkg::NUM_SLOTS,
    parameter int TICK_CYCLES = tmf_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      resetn_i,
    // apb slave
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [tmf_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic                           pready_o,
    output logic [31:0]                    prdata_o,
    output logic                           pslverr_o,
    // telegrams from the bus
    input  wire logic                      tel_in_valid_i,
    input  wire logic [tmf_pkg::SLOT_W-1:0] tel_in_slot_i,
    input  wire logic                      tel_in_port_i,
    input  wire logic                      tel_in_value_i,
    // telegrams to the bus
    output logic                           tel_out_valid_o,
    output logic [tmf_pkg::SLOT_W-1:0]     tel_out_slot_o,
    output logic                           tel_out_value_o
);

    localparam int SW = tmf_pkg::SLOT_W;

    // reset release through two flops
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // lowest set bit of a pending vector
    function automatic logic [SW-1:0] first_set(
        input logic [NUM_SLOTS-1:0] v);
        first_set = '0;
        for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
            if (v[k]) begin
                first_set = k[SW-1:0];
            end
        end
    endfunction

    // seconds tick; the divider is a parameter so benches can shorten it
    logic [31:0] tick_cnt, next_tick_cnt;
    logic        tick, next_tick;

    always_comb begin
        next_tick     = 1'b0;
        next_tick_cnt = tick_cnt + 32'h0000_0001;
        if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            next_tick_cnt = '0;
            next_tick     = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    // configuration storage
    logic [31:0] cfg        [NUM_SLOTS];
    logic [31:0] next_cfg   [NUM_SLOTS];
    logic [31:0] route      [NUM_SLOTS];
    logic [31:0] next_route [NUM_SLOTS];

    // slot status
    logic [NUM_SLOTS-1:0] pend;
    logic [NUM_SLOTS-1:0] pval;
    logic [NUM_SLOTS-1:0] running;
    logic [NUM_SLOTS-1:0] ok_a;
    logic [NUM_SLOTS-1:0] ok_b;
    logic [NUM_SLOTS-1:0] sent;
    logic [NUM_SLOTS-1:0] last_out, next_last_out;

    // emitter choice and chained delivery
    logic [SW-1:0] sel;
    logic          any_pend;
    logic          chain_en;
    logic [SW-1:0] chain_tgt;
    logic          chain_port;
    logic          conflict;
    logic          emit;

    assign any_pend   = |pend;
    assign sel        = first_set(pend);
    assign chain_en   = route[sel][tmf_pkg::ROUTE_EN_BIT];
    assign chain_tgt  = route[sel][tmf_pkg::ROUTE_TGT_LSB +: SW];
    assign chain_port = route[sel][tmf_pkg::ROUTE_PORT_BIT];
    // a chained delivery never overwrites a bus telegram for the same slot;
    // the emission waits a cycle instead, so neither event is lost
    assign conflict   = chain_en && tel_in_valid_i &&
                        (tel_in_slot_i == chain_tgt);
    assign emit       = any_pend && !conflict;

    // slots, each fed by the bus or by a chained output
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            logic hit_ext;
            logic hit_chain;
            logic ev_port;
            logic ev_value;

            assign hit_ext   = tel_in_valid_i &&
                               (tel_in_slot_i == SW'(gi));
            assign hit_chain = emit && chain_en &&
                               (chain_tgt == SW'(gi));
            assign ev_port   = hit_ext ? tel_in_port_i : chain_port;
            assign ev_value  = hit_ext ? tel_in_value_i : pval[sel];
            assign sent[gi]  = emit && (sel == SW'(gi));

            tmf_slot #(
                .DELAY_W (tmf_pkg::DELAY_W)
            ) u_slot (
                .clk_i        (core_clk_i),
                .rst_n_i      (rst_n),
                .cfg_i        (cfg[gi]),
                .tick_i       (tick),
                .ev_valid_i   (hit_ext | hit_chain),
                .ev_port_i    (ev_port),
                .ev_value_i   (ev_value),
                .sent_i       (sent[gi]),
                .send_pend_o  (pend[gi]),
                .send_value_o (pval[gi]),
                .running_o    (running[gi]),
                .valid_o      ({ok_b[gi], ok_a[gi]})
            );
        end
    endgenerate

    // outgoing telegram register
    logic          next_out_valid;
    logic [SW-1:0] next_out_slot;
    logic          next_out_value;

    always_comb begin
        next_out_valid = emit;
        next_out_slot  = emit ? sel : tel_out_slot_o;
        next_out_value = emit ? pval[sel] : tel_out_value_o;
        next_last_out  = last_out;
        if (emit) begin
            next_last_out[sel] = pval[sel];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tel_out_valid_o <= 1'b0;
            tel_out_slot_o  <= '0;
            tel_out_value_o <= 1'b0;
            last_out        <= '0;
        end else begin
            tel_out_valid_o <= next_out_valid;
            tel_out_slot_o  <= next_out_slot;
            tel_out_value_o <= next_out_value;
            last_out        <= next_last_out;
        end
    end

    // apb: one wait state; reads sampled in it, writes land on the last edge
    logic        acc;
    logic        wr_now;
    logic [3:0]  widx;
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    assign acc    = psel_i && penable_i;
    assign wr_now = acc && pready_o && pwrite_i;
    assign widx   = paddr_i[5:2];

    always_comb begin
        next_pready  = acc && !pready_o;
        next_prdata  = '0;
        next_pslverr = 1'b0;
        if (acc && !pready_o) begin
            if (paddr_i[1:0] != 2'h0) begin
                next_pslverr = 1'b1;
            end else if (paddr_i[7:6] == tmf_pkg::CFG_BASE[7:6]) begin
                next_prdata = cfg[widx];
            end else if (paddr_i[7:6] == tmf_pkg::ROUTE_BASE[7:6]) begin
                next_prdata = route[widx];
            end else if (paddr_i == tmf_pkg::STAT_RUN) begin
                next_prdata = 32'(running);
            end else if (paddr_i == tmf_pkg::STAT_OUT) begin
                next_prdata = 32'(last_out);
            end else if (paddr_i == tmf_pkg::STAT_VALID) begin
                next_prdata = {16'(ok_b), 16'(ok_a)};
            end else begin
                next_pslverr = 1'b1;
            end
            if (next_pslverr || !pwrite_i) begin
                next_prdata = next_pslverr ? 32'h0000_0000 : next_prdata;
            end else begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o  <= 1'b0;
            prdata_o  <= '0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= next_pready;
            prdata_o  <= next_prdata;
            pslverr_o <= next_pslverr;
        end
    end

    // configuration writes; status words are read-only
    always_comb begin
        for (int k = 0; k < NUM_SLOTS; k++) begin
            next_cfg[k]   = cfg[k];
            next_route[k] = route[k];
        end
        if (wr_now && paddr_i[1:0] == 2'h0) begin
            if (paddr_i[7:6] == tmf_pkg::CFG_BASE[7:6]) begin
                next_cfg[widx] = pwdata_i;
            end else if (paddr_i[7:6] == tmf_pkg::ROUTE_BASE[7:6]) begin
                next_route[widx] = pwdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < NUM_SLOTS; k++) begin
                cfg[k]   <= tmf_pkg::CFG_RESET;
                route[k] <= tmf_pkg::ROUTE_RESET;
            end
        end else begin
            for (int k = 0; k < NUM_SLOTS; k++) begin
                cfg[k]   <= next_cfg[k];
                route[k] <= next_route[k];
            end
        end
    end

endmodule

// >>> dv/tmf_checker.sv
// Purpose: port assertions for the function bank
// Assumes: one clock, resetn_i async active low
// Notes:   slot config is not tracked, so checks stay on apb and reset
`timescale 1ns/1ps
module tmf_checker (
    // clock and reset
    input wire logic                        core_clk_i,
    input wire logic                        resetn_i,
    // apb
    input wire logic                        psel_i,
    input wire logic                        penable_i,
    input wire logic                        pwrite_i,
    input wire logic [tmf_pkg::ADDR_W-1:0]  paddr_i,
    input wire logic [31:0]                 pwdata_i,
    input wire logic                        pready_o,
    input wire logic [31:0]                 prdata_o,
    input wire logic                        pslverr_o,
    // telegrams
    input wire logic                        tel_in_valid_i,
    input wire logic [tmf_pkg::SLOT_W-1:0]  tel_in_slot_i,
    input wire logic                        tel_in_port_i,
    input wire logic                        tel_in_value_i,
    input wire logic                        tel_out_valid_o,
    input wire logic [tmf_pkg::SLOT_W-1:0]  tel_out_slot_o,
    input wire logic                        tel_out_value_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // first access cycle of a transfer
    wire logic acc = psel_i && penable_i && !pready_o;
    chk_ready_wait: assert property (acc |=> pready_o)
        else $error("pready not one cycle after access");
    chk_ready_idle: assert property (!acc |=> !pready_o)
        else $error("pready without access");
    chk_bad_align: assert property (acc && paddr_i[1:0] != 2'h0 |=> pslverr_o)
        else $error("misaligned access not refused");
    chk_bad_range: assert property (acc && paddr_i >= 8'h8C |=> pslverr_o)
        else $error("unmapped access not refused");
    chk_good_addr: assert property (acc && paddr_i[1:0] == 2'h0
        && paddr_i < 8'h8C |=> !pslverr_o)
        else $error("mapped access refused");
    chk_err_zero: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
        else $error("read data on refused access");
    chk_wr_zero: assert property (pready_o && pwrite_i |-> prdata_o == 32'h0)
        else $error("read data on write");
    chk_reset_quiet: assert property ($rose(resetn_i) |-> !tel_out_valid_o [*3])
        else $error("telegram sent out of reset");
endmodule

// >>> dv/tmf_bus_model.sv
// Purpose: telegram layer that feeds slot inputs of the bank
// Assumes: caller enters send just after a rising edge
// Notes:   idle lines show the inverse of the last telegram
`timescale 1ns/1ps
module tmf_bus_model (
    // clock
    input  wire logic                        clk_i,
    // telegrams into the bank
    output logic                             tel_valid_o,
    output logic [tmf_pkg::SLOT_W-1:0]       tel_slot_o,
    output logic                             tel_port_o,
    output logic                             tel_value_o
);
    initial begin
        tel_valid_o = 1'b0;
        tel_slot_o = 4'h0;
        tel_port_o = 1'b0;
        tel_value_o = 1'b0;
    end
    // one-cycle strobe; stale fields are scrambled so none is trusted
    task automatic send(logic [3:0] s, logic p, logic v);
        @(posedge clk_i);
        tel_valid_o <= 1'b1;
        tel_slot_o <= s;
        tel_port_o <= p;
        tel_value_o <= v;
        @(posedge clk_i);
        tel_valid_o <= 1'b0;
        tel_slot_o <= ~s;
        tel_port_o <= ~p;
        tel_value_o <= ~v;
    endtask
endmodule

// >>> dv/tmf_bank_tb_top.sv
// Purpose: self-checking bench for the function bank
// Assumes: tick shortened to TCK clocks, apb answers after one wait
// Notes:   timer windows allow for the free running tick phase
`timescale 1ns/1ps
module tmf_bank_tb_top;
    localparam int TCK = 20;
    localparam int LO = TCK - 1;
    localparam int HI = 2 * TCK + 6;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] got;
    logic        gerr;
    int          num_errors = 0;
    int          total_checks = 0;
    wire logic        rdy, err, tv, tp, tval, ov, oval;
    wire logic [31:0] prd;
    wire logic [3:0]  ts, os;
    always #10 clk = ~clk;
    tmf_bus_model i_tmf_bus_model (.clk_i(clk), .tel_valid_o(tv),
        .tel_slot_o(ts), .tel_port_o(tp), .tel_value_o(tval));
    tmf_bank #(.TICK_CYCLES(TCK)) i_tmf_bank (.core_clk_i(clk),
        .resetn_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwd), .pready_o(rdy), .prdata_o(prd),
        .pslverr_o(err), .tel_in_valid_i(tv), .tel_in_slot_i(ts),
        .tel_in_port_i(tp), .tel_in_value_i(tval), .tel_out_valid_o(ov),
        .tel_out_slot_o(os), .tel_out_value_o(oval));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    // setup, access, then release after pready seen high
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        got = prd;
        gerr = err;
        chk("pready", 1, rdy);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic cfg(logic [3:0] s, logic [31:0] v);
        apb(1'b1, {2'h0, s, 2'h0}, 32'h0);
        apb(1'b1, {2'h0, s, 2'h0}, v);
    endtask
    task automatic tx(logic [3:0] s, logic p, logic v);
        i_tmf_bus_model.send(s, p, v);
    endtask
    // wait for a telegram and check where and when it came
    task automatic wo(logic [3:0] s, logic v, int lo, int hi);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ov !== 1'b1 && n < hi);
        chk("out valid", 1, ov);
        chk("out slot", s, os);
        chk("out value", v, oval);
        chk("out early", 1, n >= lo);
    endtask
    task automatic none(int c);
        repeat (c) begin
            @(posedge clk);
            chk("quiet", 0, ov);
        end
    endtask
    function automatic logic gref(int g, logic a, logic b);
        case (g)
            0: return a & b;
            1: return a | b;
            2: return a ^ b;
            3: return ~(a & b);
            4: return ~(a | b);
            default: return ~(a ^ b);
        endcase
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog far beyond the expected run
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk("cfg reset", 32'h0, got);
        apb(1'b0, 8'h8C, 32'h0);
        chk("unmapped", 1, gerr);
        apb(1'b0, 8'h02, 32'h0);
        chk("misaligned", 1, gerr);
        cfg(3, 32'h0000_0062);
        apb(1'b0, 8'h0C, 32'h0);
        chk("cfg read", 32'h0000_0062, got);
        for (int v = 0; v < 2; v++) begin
            tx(3, 0, v[0]);
            wo(3, ~v[0], 1, 4);
        end
        for (int g = 0; g < 6; g++) begin
            for (int k = 0; k < 4; k++) begin
                cfg(0, 32'h0000_0002 | 32'(g << 4));
                tx(0, 0, k[1]);
                none(6);
                tx(0, 1, k[0]);
                wo(0, gref(g, k[1], k[0]), 1, 4);
                tx(0, 0, ~k[1]);
                wo(0, gref(g, ~k[1], k[0]), 1, 4);
            end
        end
        cfg(5, 32'h0002_0001);
        tx(5, 0, 1);
        wo(5, 1, LO, HI);
        cfg(5, 32'h0002_0005);
        tx(5, 0, 1);
        wo(5, 1, 1, 4);
        tx(5, 0, 0);
        wo(5, 0, LO, HI);
        cfg(5, 32'h0002_0009);
        tx(5, 0, 1);
        wo(5, 1, LO, HI);
        tx(5, 0, 0);
        wo(5, 0, LO, HI);
        cfg(5, 32'h0002_008D);
        tx(5, 0, 1);
        wo(5, 0, 1, 4);
        wo(5, 1, LO, HI);
        cfg(5, 32'h0002_0001);
        tx(5, 0, 1);
        tx(5, 0, 0);
        wo(5, 0, 1, 4);
        none(HI);
        cfg(5, 32'h0002_0009);
        tx(5, 0, 1);
        tx(5, 0, 0);
        none(HI);
        cfg(4, 32'h0000_0062);
        apb(1'b1, 8'h4C, 32'h0000_0041);
        tx(3, 0, 1);
        wo(3, 0, 1, 4);
        wo(4, 1, 1, 4);
        cfg(5, 32'h0002_0001);
        tx(5, 0, 1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        none(HI);
        report_and_stop();
    end
endmodule
bind tmf_bank tmf_checker i_tmf_checker (.*);
